// ---- include/base_pkg.sv ----
// package: register map, field layout, timing and types of the area evaluator
package base_pkg;
	// geometry of the receiver and of the evaluation
	localparam int NUM_BEAMS   = 64;    // logical beams per measurement
	localparam int BEAM_IDX_W  = 6;     // width of a beam index
	localparam int NUM_AREAS   = 32;    // block evaluation areas
	localparam int NUM_HEIGHTS = 4;     // taught height areas
	localparam int NUM_OUTS    = 4;     // switching outputs
	localparam int HOLD_W      = 8;     // width of the hold length in measurement cycles

	// timing: system clock and trigger pulse width on the pin
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TRIG_PULSE_NS  = 10000;
	localparam int TRIG_PULSE_CYC =
		(TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte offsets on the apb bus
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PERIOD   = 8'h04;
	localparam logic [7:0] OFF_DELAY    = 8'h08;
	localparam logic [7:0] OFF_SPLIT    = 8'h0C;
	localparam logic [7:0] OFF_AREA_EN  = 8'h10;
	localparam logic [7:0] OFF_AREA_AND = 8'h14;
	localparam logic [7:0] OFF_POL      = 8'h18;
	localparam logic [7:0] OFF_OUT_MAP  = 8'h1C;
	localparam logic [7:0] OFF_HOLD     = 8'h20;
	localparam logic [7:0] OFF_STATUS   = 8'h24;
	localparam logic [7:0] OFF_AREA_LO  = 8'h28;
	localparam logic [7:0] OFF_AREA_HI  = 8'h2C;
	localparam logic [7:0] OFF_BOUND    = 8'h80; // 32 words, one per area

	// control register fields
	localparam int CTRL_TRIG_INT  = 0;  // master: internal trigger
	localparam int CTRL_SPLIT_EN  = 1;  // autosplit instead of bounds
	localparam int CTRL_SPLIT_AND = 2;  // autosplit link: 1 and, 0 or
	localparam int CTRL_TEACH     = 3;  // write 1: start height teach
	localparam int CTRL_HCLR      = 4;  // write 1: forget height areas
	localparam int CTRL_STORE_W   = 3;  // stored control bits

	// status register fields
	localparam int STAT_BUSY   = 0;
	localparam int STAT_ERR    = 1;     // write 1 to clear
	localparam int STAT_SLOT   = 4;     // three bits of used slots

	// bound word and output map layout
	localparam int BND_FIRST_LSB = 0;
	localparam int BND_LAST_LSB  = 16;
	localparam int OMAP_STRIDE   = 8;
	localparam int OMAP_W        = 6;
	localparam int OMAP_HEIGHT   = 5;   // 1: source is a height area

	// reset values
	localparam logic [31:0] PERIOD_RST = 32'h0000_2710;
	localparam logic [31:0] DELAY_RST  = 32'h0000_0000;
	localparam logic [5:0]  SPLIT_RST  = 6'h20;
	localparam logic [3:0]  POL_RST    = 4'h0;        // light switching
	localparam logic [31:0] OMAP_RST   = 32'h0003_0201;

	// one beam range of an area
	typedef struct packed {
		logic [BEAM_IDX_W-1:0] last;
		logic [BEAM_IDX_W-1:0] first;
	} base_range_t;

	// height teach sequencer
	typedef enum logic {BASE_T_IDLE, BASE_T_WAIT} base_teach_t;
endpackage

// ---- rtl/base_eval.sv ----
// module: beam area evaluation, height teach, trigger and switching outputs
//
// Overview of operation
// - master internal trigger repeats continuously
// - received trigger starts measurement sequence
// - own delay after trigger before measuring
// - trigger source internal or external, configurable
// - up to 32 area bits, two words
// - area is contiguous start to end beams
// - hold also applies to area bits
// - autosplit divides beams into equal areas
// - and link: all mapped beams interrupted
// - or link: any mapped beam interrupted
// - areas may abut or overlap freely
// - any area routable to switching output
// - four height areas, end beam interrupted
// - all beams free gives whole range
// - height areas always use or link
// - panel teach maps pins to heights
// - software teach with object reports error
// - outputs reset to light switching
// - light: area 1 drives output high
// - dark: area 1 drives output low
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module base_eval
	import base_pkg::*;
(
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RESET_N_I,
	input  wire logic                 PSEL_I,
	input  wire logic                 PENABLE_I,
	input  wire logic                 PWRITE_I,
	input  wire logic [7:0]           PADDR_I,
	input  wire logic [31:0]          PWDATA_I,
	output logic      [31:0]          PRDATA_O,
	output logic                      PREADY_O,
	output logic                      PSLVERR_O,
	input  wire logic [NUM_BEAMS-1:0] BEAM_STATE_I,
	input  wire logic                 BEAM_VALID_I,
	input  wire logic                 TRIG_IN_I,
	input  wire logic                 TEACH_PANEL_I,
	output logic                      TRIG_OUT_O,
	output logic                      MEAS_START_O,
	output logic      [NUM_OUTS-1:0]  SW_OUT_O,
	output logic                      EVAL_DONE_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// configuration registers
	logic [CTRL_STORE_W-1:0] ctrl_q;      // stored control bits
	logic [31:0]             period_q;    // internal trigger period
	logic [31:0]             delay_q;     // start delay after trigger
	logic [5:0]              split_cnt_q; // autosplit area count
	logic [NUM_AREAS-1:0]    area_en_q;   // explicit area enables
	logic [NUM_AREAS-1:0]    area_and_q;  // explicit link, 1 = and
	logic [NUM_OUTS-1:0]     pol_q;       // 1 = dark switching
	logic [31:0]             out_map_q;   // output source selection
	logic [HOLD_W-1:0]       hold_q;      // hold length in cycles
	base_range_t             bound_q [NUM_AREAS]; // explicit bounds

	// apb slave state
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic        rd_hit;

	// decode of the current request
	logic setup_ph;
	logic wr_en;
	logic wr_ctrl;
	logic bound_hit;
	logic sw_teach;
	logic sw_hclr;
	logic err_clr;
	assign setup_ph  = PSEL_I & ~PENABLE_I;
	assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I & pready_q;
	assign bound_hit = PADDR_I[7];
	assign wr_ctrl   = wr_en & (PADDR_I == OFF_CTRL);
	assign sw_teach  = wr_ctrl & PWDATA_I[CTRL_TEACH];
	assign sw_hclr   = wr_ctrl & PWDATA_I[CTRL_HCLR];
	assign err_clr   = wr_en & (PADDR_I == OFF_STATUS) & PWDATA_I[STAT_ERR];

	// control fields in use
	logic trig_int;
	logic split_en;
	logic split_and;
	assign trig_int  = ctrl_q[CTRL_TRIG_INT];
	assign split_en  = ctrl_q[CTRL_SPLIT_EN];
	assign split_and = ctrl_q[CTRL_SPLIT_AND];

	// area and height state seen by software and outputs
	logic [NUM_AREAS-1:0]   area_raw;
	logic [NUM_AREAS-1:0]   area_live;
	logic [NUM_HEIGHTS-1:0] h_raw;
	logic [NUM_HEIGHTS-1:0] h_bits_q;
	base_range_t            hrange_q [NUM_HEIGHTS];
	logic [NUM_HEIGHTS-1:0] hvalid_q;
	logic [2:0]             hslots_q;
	logic [NUM_OUTS-1:0]    panel_map_q;
	logic                   teach_err_q;
	base_teach_t            teach_st_q;

	// register read selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		if (bound_hit) begin
			rd_mux[BND_FIRST_LSB +: BEAM_IDX_W] = bound_q[PADDR_I[6:2]].first;
			rd_mux[BND_LAST_LSB +: BEAM_IDX_W]  = bound_q[PADDR_I[6:2]].last;
		end else begin
			unique case (PADDR_I)
				OFF_CTRL:     rd_mux[CTRL_STORE_W-1:0] = ctrl_q;
				OFF_PERIOD:   rd_mux = period_q;
				OFF_DELAY:    rd_mux = delay_q;
				OFF_SPLIT:    rd_mux[5:0] = split_cnt_q;
				OFF_AREA_EN:  rd_mux = area_en_q;
				OFF_AREA_AND: rd_mux = area_and_q;
				OFF_POL:      rd_mux[NUM_OUTS-1:0] = pol_q;
				OFF_OUT_MAP:  rd_mux = out_map_q;
				OFF_HOLD:     rd_mux[HOLD_W-1:0] = hold_q;
				OFF_STATUS: begin
					rd_mux[STAT_BUSY]      = (teach_st_q == BASE_T_WAIT);
					rd_mux[STAT_ERR]       = teach_err_q;
					rd_mux[STAT_SLOT +: 3] = hslots_q;
				end
				// lower and upper word of the area states
				OFF_AREA_LO:  rd_mux[15:0] = area_live[15:0];
				OFF_AREA_HI:  rd_mux[15:0] = area_live[31:16];
				default:      rd_hit = 1'b0;
			endcase
		end
	end

	// apb answer: data and error taken in setup, ready in access
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph & ~rd_hit;
			prdata_q  <= (setup_ph & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
		end
	end

	// configuration writes, taken at the access edge
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			ctrl_q      <= '0;
			period_q    <= PERIOD_RST;
			delay_q     <= DELAY_RST;
			split_cnt_q <= SPLIT_RST;
			area_en_q   <= '0;
			area_and_q  <= '0;
			pol_q       <= POL_RST;
			out_map_q   <= OMAP_RST;
			hold_q      <= '0;
			for (int i = 0; i < NUM_AREAS; i++) begin
				bound_q[i] <= '0;
			end
		end else if (wr_en) begin
			if (bound_hit) begin
				// start and end beam of one area, ranges may overlap
				bound_q[PADDR_I[6:2]].first <=
					PWDATA_I[BND_FIRST_LSB +: BEAM_IDX_W];
				bound_q[PADDR_I[6:2]].last <=
					PWDATA_I[BND_LAST_LSB +: BEAM_IDX_W];
			end
			unique case (PADDR_I)
				OFF_CTRL:     ctrl_q <= PWDATA_I[CTRL_STORE_W-1:0];
				OFF_PERIOD:   period_q <= PWDATA_I;
				OFF_DELAY:    delay_q <= PWDATA_I;
				OFF_SPLIT:    split_cnt_q <= PWDATA_I[5:0];
				OFF_AREA_EN:  area_en_q <= PWDATA_I;
				OFF_AREA_AND: area_and_q <= PWDATA_I;
				OFF_POL:      pol_q <= PWDATA_I[NUM_OUTS-1:0];
				OFF_OUT_MAP:  out_map_q <= PWDATA_I;
				OFF_HOLD:     hold_q <= PWDATA_I[HOLD_W-1:0];
				default:      ;
			endcase
		end
	end

	// trigger input synchroniser and edge detect on the second stage
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;
	logic ext_edge;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			{trig_s1_q, trig_s2_q, trig_s3_q} <= 3'h0;
		end else begin
			{trig_s1_q, trig_s2_q, trig_s3_q} <=
				{TRIG_IN_I, trig_s1_q, trig_s2_q};
		end
	end
	assign ext_edge = trig_s2_q & ~trig_s3_q;

	// free running period counter of the master
	logic [31:0] per_cnt_q;
	logic        int_evt;
	logic        trig_evt;
	assign int_evt  = trig_int & (per_cnt_q == 32'h0000_0000);
	assign trig_evt = trig_int ? int_evt : ext_edge;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I || !trig_int) begin
			per_cnt_q <= 32'h0000_0000;
		end else if (int_evt) begin
			per_cnt_q <= period_q - 32'h0000_0001;
		end else begin
			per_cnt_q <= per_cnt_q - 32'h0000_0001;
		end
	end

	// trigger pin pulse stretched to a fixed width, master only
	logic [15:0] pulse_cnt_q;
	logic        trig_out_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I || !trig_int) begin
			pulse_cnt_q <= 16'h0000;
			trig_out_q  <= 1'b0;
		end else if (int_evt) begin
			pulse_cnt_q <= 16'(TRIG_PULSE_CYC - 1);
			trig_out_q  <= 1'b1;
		end else if (pulse_cnt_q != 16'h0000) begin
			pulse_cnt_q <= pulse_cnt_q - 16'h0001;
		end else begin
			trig_out_q  <= 1'b0;
		end
	end

	// start delay: a new trigger restarts the wait
	logic [31:0] dly_cnt_q;
	logic        dly_busy_q;
	logic        meas_start_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			dly_cnt_q    <= 32'h0000_0000;
			dly_busy_q   <= 1'b0;
			meas_start_q <= 1'b0;
		end else begin
			meas_start_q <= dly_busy_q & (dly_cnt_q == 32'h0000_0000) &
				~trig_evt;
			if (trig_evt) begin
				dly_cnt_q  <= delay_q;
				dly_busy_q <= 1'b1;
			end else if (dly_busy_q) begin
				dly_busy_q <= (dly_cnt_q != 32'h0000_0000);
				dly_cnt_q  <= dly_cnt_q - 32'h0000_0001;
			end
		end
	end

	// autosplit: area index of each beam is beam * count / beams
	logic [BEAM_IDX_W-1:0] split_idx [NUM_BEAMS];
	for (genvar b = 0; b < NUM_BEAMS; b++) begin : g_split
		assign split_idx[b] = BEAM_IDX_W'((12'(b) * 12'(split_cnt_q)) >>
			BEAM_IDX_W);
	end

	// block evaluation per area with its hold stage
	for (genvar a = 0; a < NUM_AREAS; a++) begin : g_area
		logic [NUM_BEAMS-1:0] mask;    // beams mapped to this area
		logic                 link_and;
		logic                 live_q;
		logic [HOLD_W-1:0]    hcnt_q;
		// contiguous run, or equal share in autosplit
		always_comb begin
			for (int b = 0; b < NUM_BEAMS; b++) begin
				mask[b] = split_en ?
					(split_idx[b] == 6'(a) && 6'(a) < split_cnt_q) :
					(area_en_q[a] && 6'(b) >= bound_q[a].first &&
					6'(b) <= bound_q[a].last);
			end
		end
		assign link_and = split_en ? split_and : area_and_q[a];
		assign area_raw[a] = link_and ?
			((mask != '0) && ((BEAM_STATE_I & mask) == mask)) :
			((BEAM_STATE_I & mask) != '0);
		// hold keeps a set bit for hold_q further cycles
		always_ff @(posedge SYS_CLK_I) begin
			if (!RESET_N_I) begin
				live_q <= 1'b0;
				hcnt_q <= '0;
			end else if (BEAM_VALID_I) begin
				if (area_raw[a]) begin
					live_q <= 1'b1;
					hcnt_q <= hold_q;
				end else if (hcnt_q != '0) begin
					hcnt_q <= hcnt_q - 1'b1;
				end else begin
					live_q <= 1'b0;
				end
			end
		end
		assign area_live[a] = live_q;
	end

	// height areas: or of the taught range, no other link
	for (genvar h = 0; h < NUM_HEIGHTS; h++) begin : g_height
		logic [NUM_BEAMS-1:0] hmask;
		always_comb begin
			for (int b = 0; b < NUM_BEAMS; b++) begin
				hmask[b] = hvalid_q[h] && 6'(b) >= hrange_q[h].first &&
					6'(b) <= hrange_q[h].last;
			end
		end
		assign h_raw[h] = (BEAM_STATE_I & hmask) != '0;
	end

	// lowest and highest interrupted beam
	function automatic logic [5:0] first_hit(input logic [NUM_BEAMS-1:0] v);
		logic [5:0] r;
		r = '0;
		for (int i = NUM_BEAMS - 1; i >= 0; i--) begin
			if (v[i]) r = 6'(i);
		end
		return r;
	endfunction
	function automatic logic [5:0] last_hit(input logic [NUM_BEAMS-1:0] v);
		logic [5:0] r;
		r = '0;
		for (int i = 0; i < NUM_BEAMS; i++) begin
			if (v[i]) r = 6'(i);
		end
		return r;
	endfunction

	// teach result from the captured measurement
	logic        panel_s1_q;
	logic        panel_s2_q;
	logic        panel_s3_q;
	logic        from_sw_q;
	logic        capture;
	logic        all_free;
	logic        low_hit;
	logic        top_hit;
	logic        teach_ok;
	base_range_t new_range;
	assign capture  = (teach_st_q == BASE_T_WAIT) & BEAM_VALID_I;
	assign all_free = (BEAM_STATE_I == '0);
	assign low_hit  = BEAM_STATE_I[0];
	assign top_hit  = BEAM_STATE_I[NUM_BEAMS-1];
	assign teach_ok = (hslots_q < 3'(NUM_HEIGHTS)) &&
		(all_free || (!from_sw_q && (low_hit ^ top_hit)));
	assign new_range.first = (low_hit && !all_free) ?
		last_hit(BEAM_STATE_I) + 6'h01 : 6'h00;
	assign new_range.last = (top_hit && !low_hit) ?
		first_hit(BEAM_STATE_I) - 6'h01 : 6'(NUM_BEAMS - 1);

	// panel button synchroniser
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			{panel_s1_q, panel_s2_q, panel_s3_q} <= 3'h0;
		end else begin
			{panel_s1_q, panel_s2_q, panel_s3_q} <=
				{TEACH_PANEL_I, panel_s1_q, panel_s2_q};
		end
	end

	// teach sequencer waits for the next completed measurement
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			teach_st_q <= BASE_T_IDLE;
			from_sw_q  <= 1'b0;
		end else begin
			unique case (teach_st_q)
				BASE_T_IDLE: begin
					if (sw_teach || (panel_s2_q && !panel_s3_q)) begin
						teach_st_q <= BASE_T_WAIT;
						from_sw_q  <= sw_teach;
					end
				end
				BASE_T_WAIT: begin
					if (BEAM_VALID_I) teach_st_q <= BASE_T_IDLE;
				end
			endcase
		end
	end

	// height slots, pin assignment and sticky error
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I || (sw_hclr && !capture)) begin
			hvalid_q    <= '0;
			hslots_q    <= 3'h0;
			panel_map_q <= '0;
			for (int i = 0; i < NUM_HEIGHTS; i++) begin
				hrange_q[i] <= '0;
			end
		end else if (capture && teach_ok) begin
			hrange_q[hslots_q[1:0]] <= new_range;
			hvalid_q[hslots_q[1:0]] <= 1'b1;
			hslots_q <= hslots_q + 3'h1;
			if (!from_sw_q) panel_map_q[hslots_q[1:0]] <= 1'b1;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			teach_err_q <= 1'b0;
		end else begin
			// a failing teach wins over a clear in the same cycle
			teach_err_q <= (capture & ~teach_ok) |
				(teach_err_q & ~err_clr);
		end
	end

	// stage two of the evaluation: heights and done strobe
	logic eval_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			h_bits_q <= '0;
			eval_q   <= 1'b0;
		end else begin
			eval_q <= BEAM_VALID_I;
			if (BEAM_VALID_I) h_bits_q <= h_raw;
		end
	end

	// output source selection and polarity
	logic [NUM_OUTS-1:0] sel_bit;
	logic [NUM_OUTS-1:0] sw_out_q;
	logic                done_q;
	for (genvar k = 0; k < NUM_OUTS; k++) begin : g_out
		logic [OMAP_W-1:0] map_f;
		assign map_f = out_map_q[k*OMAP_STRIDE +: OMAP_W];
		assign sel_bit[k] = panel_map_q[k] ? h_bits_q[k] :
			(map_f[OMAP_HEIGHT] ? h_bits_q[map_f[1:0]] :
			area_live[map_f[4:0]]);
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			sw_out_q <= '0;
			done_q   <= 1'b0;
		end else begin
			done_q <= eval_q;
			if (eval_q) sw_out_q <= sel_bit ^ pol_q;
		end
	end

	// port drivers
	assign PRDATA_O     = prdata_q;
	assign PREADY_O     = pready_q;
	assign PSLVERR_O    = pslverr_q;
	assign TRIG_OUT_O   = trig_out_q;
	assign MEAS_START_O = meas_start_q;
	assign SW_OUT_O     = sw_out_q;
	assign EVAL_DONE_O  = done_q;

	// checks on the evaluation, teach and trigger path
	light_pol_a: assert property (eval_q && !pol_q[0] && sel_bit[0] |=>
		SW_OUT_O[0]) else $error("light output not high on area one");
	dark_pol_a: assert property (eval_q && pol_q[1] && sel_bit[1] |=>
		!SW_OUT_O[1]) else $error("dark output not low on area one");
	and_link_a: assert property (BEAM_VALID_I && !split_en &&
		area_and_q[1] && g_area[1].mask != '0 &&
		(BEAM_STATE_I & g_area[1].mask) == g_area[1].mask |=> area_live[1])
		else $error("and area not set with all beams interrupted");
	or_link_a: assert property (BEAM_VALID_I && !split_en &&
		!area_and_q[0] && (BEAM_STATE_I & g_area[0].mask) == '0 &&
		g_area[0].hcnt_q == '0 |=> !area_live[0])
		else $error("or area set with no beam interrupted");
	hold_keep_a: assert property (BEAM_VALID_I && area_live[0] &&
		!area_raw[0] && g_area[0].hcnt_q != '0 |=> area_live[0])
		else $error("held area dropped early");
	start_delay_a: assert property (trig_evt && delay_q == '0 ##1
		!trig_evt |=> MEAS_START_O) else $error("zero delay start missing");
	master_trig_a: assert property (trig_int && int_evt |=>
		TRIG_OUT_O [*2]) else $error("master trigger pulse missing");
	sw_teach_a: assert property (capture && from_sw_q && !all_free |=>
		teach_err_q) else $error("software teach with object accepted");
	free_teach_a: assert property (capture && all_free && hslots_q == 3'h0
		|=> hrange_q[0].first == 6'h00 && hrange_q[0].last == 6'h3F &&
		hvalid_q[0]) else $error("free teach not whole range");
	pol_reset_a: assert property ($past(!RESET_N_I) |->
		pol_q == POL_RST) else $error("polarity not light after reset");
	split_eval_c: cover property (BEAM_VALID_I && split_en ##2 EVAL_DONE_O);
	ext_start_c: cover property (!trig_int && ext_edge ##[1:20] MEAS_START_O);
	panel_teach_c: cover property (capture && teach_ok && !from_sw_q);
	apb_err_c: cover property (PREADY_O && PSLVERR_O);
endmodule

// ---- test/base_beam_src.sv ----
// beam source model: hands finished measurements to the evaluator
`timescale 1ns/1ps
module base_beam_src
	import base_pkg::*;
(
	input  wire logic                 clk_i,          // system clock
	input  wire logic                 req_i,          // measurement wanted
	input  wire logic [NUM_BEAMS-1:0] pat_i,          // interrupted beams
	output logic      [NUM_BEAMS-1:0] state_o = '0,   // beam states out
	output logic                      valid_o = 1'b0  // measurement done
);
	// states only mean something with valid; scrambled otherwise
	always @(posedge clk_i) begin
		valid_o <= req_i;
		state_o <= req_i ? pat_i : ~state_o;
	end
endmodule

// ---- test/beam_area_switching_eval_test.sv ----
// self-checking bench of the beam area evaluator
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end end
module beam_area_switching_eval_test
	import base_pkg::*;
;
	logic                 sys_clk;     // 100 MHz clock
	logic                 reset_n;     // synchronous reset, active low
	logic                 psel;        // apb select
	logic                 penable;     // apb access phase
	logic                 pwrite;      // apb direction
	logic [7:0]           paddr;       // apb byte address
	logic [31:0]          pwdata;      // apb write data
	logic [31:0]          prdata;      // apb read data
	logic                 pready;      // apb answer
	logic                 pslverr;     // apb error
	logic                 trig_in;     // external trigger pin
	logic                 trig_out;    // master trigger pin
	logic                 meas_start;  // measurement start pulse
	logic                 eval_done;   // outputs updated
	logic                 req;         // ask model for a measurement
	logic                 panel;       // panel teach button
	logic                 beam_valid;  // model measurement done
	logic [NUM_BEAMS-1:0] pat;         // pattern for the model
	logic [NUM_BEAMS-1:0] beams;       // model beam states
	logic [NUM_OUTS-1:0]  sw_out;      // switching outputs
	logic [3:0]           pol_q;       // polarity last written
	logic [31:0]          rd;          // last read word
	logic                 err;         // last slave error
	int                   bad_count;
	int                   total_checks;
	int                   cyc;         // negedges since start

	base_eval base_eval_i (
		.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .BEAM_STATE_I(beams),
		.BEAM_VALID_I(beam_valid), .TRIG_IN_I(trig_in),
		.TEACH_PANEL_I(panel), .TRIG_OUT_O(trig_out),
		.MEAS_START_O(meas_start), .SW_OUT_O(sw_out),
		.EVAL_DONE_O(eval_done));
	base_beam_src base_beam_src_i (.clk_i(sys_clk), .req_i(req),
		.pat_i(pat), .state_o(beams), .valid_o(beam_valid));

	// clock and cycle count
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) cyc <= cyc + 1;

	// report counts, verdict, end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watched outputs by number
	function automatic logic mon(int s);
		case (s)
		0: return trig_out;
		1: return meas_start;
		2: return eval_done;
		3: return pready;
		default: return !trig_out;
		endcase
	endfunction

	// bounded wait at negedges until watched output is high
	task automatic wait_hi(input int s, input int lim, output int t);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (mon(s) !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				bad_count++;
				$display("CHECK FAILED wait %0d exp 1 got none", s);
				stop_test;
			end
		end
		t = cyc;
	endtask

	// one apb transfer, held until pready is sampled at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED pready exp 1 got none");
			stop_test;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// one measurement through the model, wait for outputs
	task automatic meas(input logic [NUM_BEAMS-1:0] p);
		int t;
		@(posedge sys_clk);
		pat <= p;
		req <= 1'b1;
		@(posedge sys_clk);
		req <= 1'b0;
		wait_hi(2, 20, t);
	endtask

	// measure, then judge outputs and both area words
	task automatic mchk(input logic [NUM_BEAMS-1:0] p,
		input logic [31:0] lo, input logic [31:0] hi);
		meas(p);
		`CHK("sw_out", {lo[0], lo[3], lo[2], lo[1]} ^ pol_q, sw_out)
		apb(1'b0, OFF_AREA_LO, 32'h0000_0000);
		`CHK("area_lo", lo, rd)
		apb(1'b0, OFF_AREA_HI, 32'h0000_0000);
		`CHK("area_hi", hi, rd)
	endtask

	// reset values and unmapped address
	task automatic t_reset;
		logic [7:0]  ad [5];
		logic [31:0] ex [5];
		ad = '{OFF_PERIOD, OFF_DELAY, OFF_SPLIT, OFF_POL, OFF_OUT_MAP};
		ex = '{PERIOD_RST, DELAY_RST, {26'h0, SPLIT_RST}, {28'h0, POL_RST},
			OMAP_RST};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ad[i], 32'h0000_0000);
			`CHK("reset value", ex[i], rd)
		end
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, err)
		$display("done: reset");
	endtask

	// explicit areas: or, and, overlap, abut, single beam, polarity
	task automatic t_areas;
		wr(OFF_BOUND, 32'h0003_0000);
		wr(OFF_BOUND + 8'h04, 32'h0003_0000);
		wr(OFF_BOUND + 8'h08, 32'h003F_003F);
		wr(OFF_BOUND + 8'h0C, 32'h0007_0004);
		wr(OFF_AREA_EN, 32'h0000_000F);
		wr(OFF_AREA_AND, 32'h0000_0002);
		wr(OFF_HOLD, 32'h0000_0000);
		mchk(64'h0000_0000_0000_0004, 32'h0000_0001, 32'h0000_0000);
		mchk(64'h8000_0000_0000_000F, 32'h0000_0007, 32'h0000_0000);
		pol_q = 4'hF;
		wr(OFF_POL, 32'h0000_000F);
		mchk(64'h8000_0000_0000_000F, 32'h0000_0007, 32'h0000_0000);
		mchk(64'h0000_0000_0000_0000, 32'h0000_0000, 32'h0000_0000);
		pol_q = 4'h0;
		wr(OFF_POL, 32'h0000_0000);
		$display("done: areas");
	endtask

	// area bit held for two further measurements
	task automatic t_hold;
		wr(OFF_HOLD, 32'h0000_0002);
		mchk(64'h0000_0000_0000_0004, 32'h0000_0001, 32'h0000_0000);
		mchk(64'h0000_0000_0000_0000, 32'h0000_0001, 32'h0000_0000);
		mchk(64'h0000_0000_0000_0000, 32'h0000_0001, 32'h0000_0000);
		mchk(64'h0000_0000_0000_0000, 32'h0000_0000, 32'h0000_0000);
		wr(OFF_HOLD, 32'h0000_0000);
		$display("done: hold");
	endtask

	// autosplit with 32 and 16 areas, or and and
	task automatic t_split;
		wr(OFF_CTRL, 32'h0000_0002);
		mchk(64'h8000_0000_0000_0000, 32'h0000_0000, 32'h0000_8000);
		wr(OFF_CTRL, 32'h0000_0006);
		mchk(64'h8000_0000_0000_0003, 32'h0000_0001, 32'h0000_0000);
		wr(OFF_SPLIT, 32'h0000_0010);
		wr(OFF_CTRL, 32'h0000_0002);
		mchk(64'h8000_0000_0000_0000, 32'h0000_8000, 32'h0000_0000);
		$display("done: split");
	endtask

	// height teach: software free field succeeds, software object gives error, panel teach maps a pin
	task automatic t_teach;
		wr(OFF_CTRL, 32'h0000_0008);
		meas(64'h0000_0000_0000_0000);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		`CHK("teach free", 32'h0000_0010, rd)
		wr(OFF_CTRL, 32'h0000_0008);
		meas(64'h0000_0000_0000_0001);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		`CHK("teach object", 32'h0000_0012, rd)
		@(posedge sys_clk);
		panel <= 1'b1;
		repeat (4) @(posedge sys_clk);
		panel <= 1'b0;
		meas(64'h0000_0000_0000_0001);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		`CHK("teach panel", 32'h0000_0022, rd)
		meas(64'h0000_0000_0000_0020);
		`CHK("panel pin hit", 1'b1, sw_out[1])
		meas(64'h0000_0000_0000_0001);
		`CHK("panel pin free", 1'b0, sw_out[1])
		$display("done: teach");
	endtask

	// master trigger: period, pulse width, start delay
	task automatic t_int;
		int t0, t1, tf, t2;
		wr(OFF_DELAY, 32'h0000_0005);
		wr(OFF_PERIOD, 32'h0000_07D0);
		wr(OFF_CTRL, 32'h0000_0001);
		wait_hi(0, 2100, t0);
		wait_hi(4, 1100, t0);
		wait_hi(0, 2100, t0);
		wait_hi(1, 20, t1);
		wait_hi(4, 1100, tf);
		wait_hi(0, 2100, t2);
		`CHK("start delay", 6, t1 - t0)
		`CHK("pulse width", TRIG_PULSE_CYC, tf - t0)
		`CHK("trig period", 2000, t2 - t0)
		$display("done: internal trigger");
	endtask

	// external trigger pin starts measurement after the delay
	task automatic t_ext;
		int t0, t1;
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_DELAY, 32'h0000_0000);
		repeat (1100) @(posedge sys_clk);
		t0 = cyc;
		trig_in <= 1'b1;
		wait_hi(1, 20, t1);
		`CHK("ext delay", 4, t1 - t0)
		`CHK("no master trig", 1'b0, trig_out)
		@(posedge sys_clk);
		trig_in <= 1'b0;
		$display("done: external trigger");
	endtask

	// reset, then all scenarios
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{trig_in, req, pat, pol_q, reset_n, panel} = '0;
		{bad_count, total_checks, cyc} = '0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_areas();
		t_hold();
		t_split();
		t_teach();
		t_int();
		t_ext();
		stop_test();
	end
endmodule
